// ---- mfd_regs.svh ----
// Constants for the multicast forwarding decision block.
`ifndef MFD_REGS_SVH
`define MFD_REGS_SVH
`define MFD_MAC_MC_BIT      40
`define MFD_IPV4_MC_PREFIX  4'hE
`define MFD_IPV6_MC_PREFIX  8'hFF
`define MFD_V4_MAC_BASE     48'h01005E000000
`define MFD_V6_MAC_BASE     48'h333300000000
`define MFD_RESULT_LATENCY  2
`define MFD_READY_RST       1'h1
`endif

// ---- mfd_pkg.sv ----
// Types shared by the multicast forwarding decision modules.
package mfd_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ISSUE,
		ST_WAIT,
		ST_RESOLVE
	} mfd_state_e;

	typedef enum logic [2:0] {
		SRC_DEFAULT,
		SRC_BRIDGE,
		SRC_L3,
		SRC_DISCARD,
		SRC_CTRL
	} mfd_src_e;
endpackage

// ---- mfd_cls_if.sv ----
// Interface that carries classification and decision signals inside the block.
`timescale 1ns/1ps
`default_nettype none
interface mfd_cls_if #(
	parameter int PORTS = 16
) ();
	logic [47:0]      dmac;
	logic [127:0]     dip;
	logic             is_ipv4;
	logic             is_ipv6;
	logic             is_ctrl;
	logic             mac_mcast;
	logic             v4_mcast;
	logic             v6_mcast;
	logic             ip_mcast;
	logic [47:0]      mapped_mac;
	logic             l2_only;
	logic             discard_unknown;
	logic             l3_hit;
	logic             br_hit;
	logic [PORTS-1:0] l3_pmap;
	logic [PORTS-1:0] br_pmap;
	logic [PORTS-1:0] dflt_pmap;
	logic [PORTS-1:0] pmap;
	logic             discard;
	mfd_pkg::mfd_src_e src;

	modport cls (
		input  dmac, dip, is_ipv4, is_ipv6,
		output mac_mcast, v4_mcast, v6_mcast, ip_mcast, mapped_mac
	);
	modport dec (
		input  ip_mcast, is_ctrl, l2_only, discard_unknown, l3_hit, br_hit,
		input  l3_pmap, br_pmap, dflt_pmap,
		output pmap, discard, src
	);
	modport top (
		output dmac, dip, is_ipv4, is_ipv6, is_ctrl, l2_only, discard_unknown,
		output l3_hit, br_hit, l3_pmap, br_pmap, dflt_pmap,
		input  mac_mcast, v4_mcast, v6_mcast, ip_mcast, mapped_mac, pmap, discard, src
	);
endinterface
`default_nettype wire

// ---- mfd_classify.sv ----
// Address classification and multicast MAC derivation.
`timescale 1ns/1ps
`default_nettype none
`include "mfd_regs.svh"
module mfd_classify (
	// Classification signals
	mfd_cls_if.cls bus
);
	wire v4_hit;
	wire v6_hit;

	assign v4_hit = bus.is_ipv4 && (bus.dip[31:28] == `MFD_IPV4_MC_PREFIX);
	assign v6_hit = bus.is_ipv6 && (bus.dip[127:120] == `MFD_IPV6_MC_PREFIX);

	assign bus.v4_mcast  = v4_hit;
	assign bus.v6_mcast  = v6_hit;
	assign bus.ip_mcast  = v4_hit | v6_hit;
	// Broadcast has bit zero of the first octet set, so it counts as multicast.
	assign bus.mac_mcast = bus.dmac[`MFD_MAC_MC_BIT];

	// Low 23 group bits go into the IPv4 range, so groups differing only above alias.
	assign bus.mapped_mac = v4_hit ? (`MFD_V4_MAC_BASE | {25'h0, bus.dip[22:0]}) :
		v6_hit ? (`MFD_V6_MAC_BASE | {16'h0000, bus.dip[31:0]}) :
		bus.dmac;
endmodule
`default_nettype wire

// ---- mfd_decide.sv ----
// Priority selection of the destination port map.
`timescale 1ns/1ps
`default_nettype none
module mfd_decide (
	// Decision signals
	mfd_cls_if.dec bus
);
	wire l3_mode;
	wire ctrl_sel;
	wire l3_sel;
	wire unk_discard;

	assign l3_mode     = !bus.l2_only;
	assign ctrl_sel    = l3_mode && bus.is_ctrl;
	assign l3_sel      = l3_mode && bus.ip_mcast && bus.l3_hit;
	assign unk_discard = l3_mode && bus.ip_mcast && bus.discard_unknown;

	assign bus.src = ctrl_sel ? mfd_pkg::SRC_CTRL :
		l3_sel ? mfd_pkg::SRC_L3 :
		bus.br_hit ? mfd_pkg::SRC_BRIDGE :
		unk_discard ? mfd_pkg::SRC_DISCARD :
		mfd_pkg::SRC_DEFAULT;

	assign bus.pmap = (bus.src == mfd_pkg::SRC_L3) ? bus.l3_pmap :
		(bus.src == mfd_pkg::SRC_BRIDGE) ? bus.br_pmap :
		(bus.src == mfd_pkg::SRC_DEFAULT) ? bus.dflt_pmap :
		'0;
	assign bus.discard = (bus.src == mfd_pkg::SRC_DISCARD);
endmodule
`default_nettype wire

// ---- mfd_top.sv ----
// Multicast forwarding decision: frame intake, table searches and result.
`timescale 1ns/1ps
`default_nettype none
`include "mfd_regs.svh"
module mfd_top #(
	parameter int PORTS = 16
) (
	// Clock and reset
	input  wire logic             CLOCK,
	input  wire logic             RST_B,
	// Frame descriptor from the parser
	input  wire logic             FRM_VALID,
	output logic                  FRM_READY,
	input  wire logic [47:0]      FRM_DMAC,
	input  wire logic [47:0]      FRM_SMAC,
	input  wire logic [127:0]     FRM_DIP,
	input  wire logic             FRM_IS_IPV4,
	input  wire logic             FRM_IS_IPV6,
	input  wire logic             FRM_IS_CTRL,
	// Configuration
	input  wire logic             FWD_L2_ONLY,
	input  wire logic             UNKNOWN_IP_MCAST_DISCARD,
	input  wire logic [PORTS-1:0] DEFAULT_MCAST_PORTMAP,
	// L3 multicast table search
	output logic                  L3_REQ,
	output logic [127:0]          L3_KEY,
	output logic                  L3_KEY_IPV6,
	input  wire logic             L3_VALID,
	input  wire logic             L3_HIT,
	input  wire logic [PORTS-1:0] L3_PMAP,
	// Bridging table search
	output logic                  BR_REQ,
	output logic [47:0]           BR_KEY,
	input  wire logic             BR_VALID,
	input  wire logic             BR_HIT,
	input  wire logic [PORTS-1:0] BR_PMAP,
	// Source address learning
	output logic                  LEARN_EN,
	output logic [47:0]           LEARN_MAC,
	// Forwarding result
	output logic                  RES_VALID,
	output logic [PORTS-1:0]      RES_PMAP,
	output logic                  RES_DISCARD,
	output logic                  RES_CTRL,
	output logic                  RES_FROM_L3,
	output logic                  RES_DA_MCAST,
	output logic [47:0]           RES_MAPPED_MAC
);
	mfd_cls_if #(.PORTS(PORTS)) bus ();

	mfd_pkg::mfd_state_e st_r;
	mfd_pkg::mfd_state_e st_nxt;

	logic             ready_r;
	logic [47:0]      dmac_r;
	logic [127:0]     dip_r;
	logic             ipv4_r;
	logic             ipv6_r;
	logic             ctrl_r;
	logic             l3_req_r;
	logic             br_req_r;
	logic             br_done_r;
	logic             l3_done_r;
	logic             br_hit_r;
	logic             l3_hit_r;
	logic [PORTS-1:0] br_pmap_r;
	logic [PORTS-1:0] l3_pmap_r;
	logic             learn_en_r;
	logic [47:0]      learn_mac_r;
	logic             res_valid_r;
	logic [PORTS-1:0] res_pmap_r;
	logic             res_discard_r;
	logic             res_ctrl_r;
	logic             res_l3_r;
	logic             res_da_mc_r;
	logic [47:0]      res_mac_r;

	wire take;
	wire l3_need;
	wire br_now;
	wire l3_now;
	wire both_done;
	wire in_wait;

	mfd_classify u_classify (
		.bus (bus)
	);

	mfd_decide u_decide (
		.bus (bus)
	);

	assign bus.dmac            = dmac_r;
	assign bus.dip             = dip_r;
	assign bus.is_ipv4         = ipv4_r;
	assign bus.is_ipv6         = ipv6_r;
	assign bus.is_ctrl         = ctrl_r;
	assign bus.l2_only         = FWD_L2_ONLY;
	assign bus.discard_unknown = UNKNOWN_IP_MCAST_DISCARD;
	assign bus.l3_hit          = l3_hit_r;
	assign bus.br_hit          = br_hit_r;
	assign bus.l3_pmap         = l3_pmap_r;
	assign bus.br_pmap         = br_pmap_r;
	assign bus.dflt_pmap       = DEFAULT_MCAST_PORTMAP;

	assign take      = FRM_VALID && ready_r;
	assign l3_need   = !FWD_L2_ONLY && bus.ip_mcast;
	assign in_wait   = (st_r == mfd_pkg::ST_WAIT);
	assign br_now    = br_done_r || BR_VALID;
	assign l3_now    = l3_done_r || L3_VALID;
	assign both_done = in_wait && br_now && l3_now;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			mfd_pkg::ST_IDLE: begin
				if (take) begin
					st_nxt = mfd_pkg::ST_ISSUE;
				end
			end
			mfd_pkg::ST_ISSUE: begin
				st_nxt = mfd_pkg::ST_WAIT;
			end
			mfd_pkg::ST_WAIT: begin
				if (both_done) begin
					st_nxt = mfd_pkg::ST_RESOLVE;
				end
			end
			mfd_pkg::ST_RESOLVE: begin
				st_nxt = mfd_pkg::ST_IDLE;
			end
			default: begin
				st_nxt = mfd_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			st_r    <= mfd_pkg::ST_IDLE;
			ready_r <= `MFD_READY_RST;
		end else begin
			st_r    <= st_nxt;
			ready_r <= (st_nxt == mfd_pkg::ST_IDLE);
		end
	end

	// Frame fields are held until the next frame is taken.
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			dmac_r <= 48'h000000000000;
			dip_r  <= '0;
			ipv4_r <= 1'h0;
			ipv6_r <= 1'h0;
			ctrl_r <= 1'h0;
		end else if (take) begin
			dmac_r <= FRM_DMAC;
			dip_r  <= FRM_DIP;
			ipv4_r <= FRM_IS_IPV4;
			ipv6_r <= FRM_IS_IPV6;
			ctrl_r <= FRM_IS_CTRL;
		end
	end

	// A multicast source address never raises LEARN_EN, though LEARN_MAC still loads it.
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			learn_en_r  <= 1'h0;
			learn_mac_r <= 48'h000000000000;
		end else begin
			learn_en_r  <= take && !FRM_SMAC[`MFD_MAC_MC_BIT];
			learn_mac_r <= take ? FRM_SMAC : learn_mac_r;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			br_req_r <= 1'h0;
			l3_req_r <= 1'h0;
		end else begin
			br_req_r <= (st_r == mfd_pkg::ST_ISSUE);
			l3_req_r <= (st_r == mfd_pkg::ST_ISSUE) && l3_need;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			br_done_r <= 1'h0;
			br_hit_r  <= 1'h0;
			br_pmap_r <= '0;
		end else if (st_r == mfd_pkg::ST_ISSUE) begin
			br_done_r <= 1'h0;
			br_hit_r  <= 1'h0;
		end else if (in_wait && BR_VALID) begin
			br_done_r <= 1'h1;
			br_hit_r  <= BR_HIT;
			br_pmap_r <= BR_PMAP;
		end
	end

	// When no L3 search is made the L3 side counts as a completed miss.
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			l3_done_r <= 1'h0;
			l3_hit_r  <= 1'h0;
			l3_pmap_r <= '0;
		end else if (st_r == mfd_pkg::ST_ISSUE) begin
			l3_done_r <= !l3_need;
			l3_hit_r  <= 1'h0;
		end else if (in_wait && L3_VALID && !l3_done_r) begin
			l3_done_r <= 1'h1;
			l3_hit_r  <= L3_HIT;
			l3_pmap_r <= L3_PMAP;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			res_valid_r   <= 1'h0;
			res_pmap_r    <= '0;
			res_discard_r <= 1'h0;
			res_ctrl_r    <= 1'h0;
			res_l3_r      <= 1'h0;
			res_da_mc_r   <= 1'h0;
			res_mac_r     <= 48'h000000000000;
		end else begin
			res_valid_r <= (st_r == mfd_pkg::ST_RESOLVE);
			if (st_r == mfd_pkg::ST_RESOLVE) begin
				res_pmap_r    <= bus.pmap;
				res_discard_r <= bus.discard;
				res_ctrl_r    <= (bus.src == mfd_pkg::SRC_CTRL);
				res_l3_r      <= (bus.src == mfd_pkg::SRC_L3);
				res_da_mc_r   <= bus.mac_mcast;
				res_mac_r     <= bus.mapped_mac;
			end
		end
	end

	assign FRM_READY      = ready_r;
	assign L3_REQ         = l3_req_r;
	assign L3_KEY         = dip_r;
	assign L3_KEY_IPV6    = ipv6_r;
	assign BR_REQ         = br_req_r;
	assign BR_KEY         = dmac_r;
	assign LEARN_EN       = learn_en_r;
	assign LEARN_MAC      = learn_mac_r;
	assign RES_VALID      = res_valid_r;
	assign RES_PMAP       = res_pmap_r;
	assign RES_DISCARD    = res_discard_r;
	assign RES_CTRL       = res_ctrl_r;
	assign RES_FROM_L3    = res_l3_r;
	assign RES_DA_MCAST   = res_da_mc_r;
	assign RES_MAPPED_MAC = res_mac_r;

	l2_no_l3_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_ISSUE && FWD_L2_ONLY) |=> !L3_REQ && BR_REQ)
		else $error("L3 search issued in L2-only mode.");
	l3_first_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_ISSUE && !FWD_L2_ONLY && bus.ip_mcast) |=> L3_REQ && BR_REQ)
		else $error("IP multicast frame not searched in L3 table.");
	l3_wins_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_RESOLVE && !FWD_L2_ONLY && bus.ip_mcast && l3_hit_r && !ctrl_r)
		|=> RES_VALID && RES_FROM_L3 && RES_PMAP == $past(l3_pmap_r))
		else $error("L3 hit did not give the L3 port map.");
	bridge_hit_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_RESOLVE && br_hit_r && !ctrl_r
		&& !(!FWD_L2_ONLY && bus.ip_mcast && l3_hit_r))
		|=> RES_PMAP == $past(br_pmap_r) && !RES_DISCARD)
		else $error("Bridging hit did not give the bridging port map.");
	default_map_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_RESOLVE && !br_hit_r && !bus.ip_mcast && !ctrl_r)
		|=> RES_PMAP == $past(DEFAULT_MCAST_PORTMAP) && !RES_DISCARD)
		else $error("Non-IP miss did not use the default port map.");
	unknown_ip_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_RESOLVE && !FWD_L2_ONLY && bus.ip_mcast
		&& !l3_hit_r && !br_hit_r && !ctrl_r)
		|=> RES_DISCARD == $past(UNKNOWN_IP_MCAST_DISCARD)
		&& (RES_DISCARD || RES_PMAP == $past(DEFAULT_MCAST_PORTMAP)))
		else $error("Unknown IP multicast handled against the discard bit.");
	ctrl_excl_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_RESOLVE && !FWD_L2_ONLY && ctrl_r)
		|=> RES_CTRL && !RES_DISCARD && RES_PMAP == '0)
		else $error("Control frame took the generic path.");
	bridge_key_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		$rose(BR_REQ) |-> BR_KEY == $past(dmac_r) && $past(st_r == mfd_pkg::ST_ISSUE))
		else $error("Bridging search key is not the destination MAC.");
	l3_only_ip_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		L3_REQ |-> $past(bus.ip_mcast) && !$past(FWD_L2_ONLY))
		else $error("L3 search made for a non-multicast IP address.");
	v4_class_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_ISSUE && !FWD_L2_ONLY && ipv4_r && !ipv6_r)
		|=> L3_REQ == ($past(dip_r[31:28]) == 4'hE))
		else $error("IPv4 multicast range misclassified.");
	v6_class_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_ISSUE && !FWD_L2_ONLY && ipv6_r && !ipv4_r)
		|=> L3_REQ == ($past(dip_r[127:120]) == 8'hFF))
		else $error("IPv6 multicast prefix misclassified.");
	v4_mac_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_RESOLVE && bus.v4_mcast)
		|=> RES_MAPPED_MAC[47:23] == 25'h0200BC && RES_MAPPED_MAC[22:0] == $past(dip_r[22:0]))
		else $error("IPv4 group MAC mapping wrong.");
	v6_mac_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(st_r == mfd_pkg::ST_RESOLVE && bus.v6_mcast && !bus.v4_mcast)
		|=> RES_MAPPED_MAC[47:32] == 16'h3333 && RES_MAPPED_MAC[31:0] == $past(dip_r[31:0]))
		else $error("IPv6 group MAC mapping wrong.");
	learn_uc_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		LEARN_EN |-> !LEARN_MAC[`MFD_MAC_MC_BIT] && $past(take))
		else $error("Multicast source address offered for learning.");
	da_mcast_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		RES_VALID |-> RES_DA_MCAST == dmac_r[`MFD_MAC_MC_BIT])
		else $error("Destination multicast flag wrong.");
	fixed_lat_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
		both_done |-> ##2 (RES_VALID && !(RES_DISCARD && RES_PMAP != '0)) ##1 !RES_VALID)
		else $error("Result latency or exclusivity broken.");
endmodule
`default_nettype wire

// ---- mfd_lookup_model.sv ----
// Behavioural lookup table that answers search requests after a set delay.
`timescale 1ns/1ps
`default_nettype none
module mfd_lookup_model #(
	parameter int KW = 48,
	parameter int PW = 16
) (
	// Clock
	input  wire logic          CLOCK,
	// Search request
	input  wire logic          REQ,
	input  wire logic [KW-1:0] KEY,
	// Answer settings
	input  wire logic          CFG_HIT,
	input  wire logic [PW-1:0] CFG_PMAP,
	input  wire logic [3:0]    CFG_DLY,
	// Answer
	output logic               VALID,
	output logic               HIT,
	output logic [PW-1:0]      PMAP,
	// Observation
	output logic [KW-1:0]      KEY_SEEN,
	output logic [7:0]         REQ_COUNT
);
	logic [3:0] cnt_r = 4'h0;
	initial begin
		VALID = 1'b0;
		HIT = 1'b0;
		PMAP = '0;
		KEY_SEEN = '0;
		REQ_COUNT = 8'h00;
	end
	// Hit and map toggle outside the request and answer cycles so a stale sample is caught.
	always @(posedge CLOCK) begin
		VALID <= 1'b0;
		if (REQ === 1'b1) begin
			KEY_SEEN <= KEY;
			REQ_COUNT <= REQ_COUNT + 8'h01;
			cnt_r <= CFG_DLY;
		end else if (cnt_r == 4'h1) begin
			VALID <= 1'b1;
			HIT <= CFG_HIT;
			PMAP <= CFG_PMAP;
			cnt_r <= 4'h0;
		end else begin
			if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end
			HIT <= ~HIT;
			PMAP <= ~PMAP;
		end
	end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking testbench for the multicast forwarding decision block.
`timescale 1ns/1ps
`default_nettype none
`include "mfd_regs.svh"
module tb;
	localparam logic [47:0]  v4_da = 48'h01005E2BCDEF;
	localparam logic [127:0] v4_ip = 128'hE1ABCDEF;
	localparam logic [47:0]  v6_da = 48'h333312345678;
	localparam logic [127:0] v6_ip = {8'hFF, 88'h02, 32'h12345678};
	logic CLOCK = 1'b0;
	logic RST_B = 1'b0;
	logic FRM_VALID = 1'b0;
	logic [47:0] FRM_DMAC = 48'h0;
	logic [47:0] FRM_SMAC = 48'h0;
	logic [127:0] FRM_DIP = 128'h0;
	logic FRM_IS_IPV4 = 1'b0;
	logic FRM_IS_IPV6 = 1'b0;
	logic FRM_IS_CTRL = 1'b0;
	logic FWD_L2_ONLY = 1'b0;
	logic UNKNOWN_IP_MCAST_DISCARD = 1'b0;
	logic [15:0] DEFAULT_MCAST_PORTMAP = 16'h00F0;
	logic FRM_READY, L3_REQ, L3_KEY_IPV6, L3_VALID, L3_HIT, BR_REQ, BR_VALID, BR_HIT;
	logic LEARN_EN, RES_VALID, RES_DISCARD, RES_CTRL, RES_FROM_L3, RES_DA_MCAST;
	logic [127:0] L3_KEY, l3_key_seen;
	logic [47:0] BR_KEY, LEARN_MAC, RES_MAPPED_MAC, br_key_seen;
	logic [47:0] sa_c = 48'h001122334455;
	logic [15:0] L3_PMAP, BR_PMAP, RES_PMAP, l3_pm_c, br_pm_c;
	logic [7:0] l3_cnt, br_cnt;
	logic [3:0] l3_dly = 4'h1;
	logic [3:0] br_dly = 4'h1;
	logic l3_hit_c, br_hit_c, l2_c, dis_c;
	int error_cnt = 0;
	int check_count = 0;

	always #5 CLOCK = ~CLOCK;

	mfd_top #(.PORTS(16)) i_mfd_top (
		.CLOCK, .RST_B, .FRM_VALID, .FRM_READY, .FRM_DMAC, .FRM_SMAC, .FRM_DIP,
		.FRM_IS_IPV4, .FRM_IS_IPV6, .FRM_IS_CTRL, .FWD_L2_ONLY, .UNKNOWN_IP_MCAST_DISCARD,
		.DEFAULT_MCAST_PORTMAP, .L3_REQ, .L3_KEY, .L3_KEY_IPV6, .L3_VALID, .L3_HIT,
		.L3_PMAP, .BR_REQ, .BR_KEY, .BR_VALID, .BR_HIT, .BR_PMAP, .LEARN_EN, .LEARN_MAC,
		.RES_VALID, .RES_PMAP, .RES_DISCARD, .RES_CTRL, .RES_FROM_L3, .RES_DA_MCAST,
		.RES_MAPPED_MAC
	);
	mfd_lookup_model #(.KW(128), .PW(16)) i_mfd_lookup_model (.CLOCK, .REQ(L3_REQ),
		.KEY(L3_KEY), .CFG_HIT(l3_hit_c), .CFG_PMAP(l3_pm_c), .CFG_DLY(l3_dly),
		.VALID(L3_VALID), .HIT(L3_HIT), .PMAP(L3_PMAP), .KEY_SEEN(l3_key_seen),
		.REQ_COUNT(l3_cnt));
	mfd_lookup_model #(.KW(48), .PW(16)) i_mfd_lookup_model_br (.CLOCK, .REQ(BR_REQ),
		.KEY(BR_KEY), .CFG_HIT(br_hit_c), .CFG_PMAP(br_pm_c), .CFG_DLY(br_dly),
		.VALID(BR_VALID), .HIT(BR_HIT), .PMAP(BR_PMAP), .KEY_SEEN(br_key_seen),
		.REQ_COUNT(br_cnt));

	task automatic chk_addr(input logic [127:0] got, input logic [127:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_map(input logic [15:0] got, input logic [15:0] exp);
		chk_addr({112'h0, got}, {112'h0, exp});
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		chk_addr({127'h0, got}, {127'h0, exp});
	endtask

	task automatic cfg(input logic lh, input logic [15:0] lp, input logic bh,
			input logic [15:0] bp);
		l3_hit_c = lh;
		l3_pm_c = lp;
		br_hit_c = bh;
		br_pm_c = bp;
	endtask

	// Kind bits are {control, IPv6, IPv4}; result bits are {from L3, discard}.
	task automatic frame(input logic [47:0] da, input logic [127:0] ip,
			input logic [2:0] kind, input logic [15:0] epm, input logic [1:0] eres);
		int n;
		int last;
		logic lrn;
		logic [47:0] lmac;
		logic [7:0] c3;
		logic mc4;
		logic mc6;
		logic l3x;
		logic [47:0] emac;
		mc4 = kind[0] && ip[31:28] == 4'hE;
		mc6 = kind[1] && ip[127:120] == 8'hFF;
		l3x = !l2_c && (mc4 || mc6);
		emac = mc4 ? {24'h01005E, 1'b0, ip[22:0]} : (mc6 ? {16'h3333, ip[31:0]} : da);
		c3 = l3_cnt;
		lrn = 1'b0;
		lmac = 48'h0;
		last = 0;
		FWD_L2_ONLY <= l2_c;
		UNKNOWN_IP_MCAST_DISCARD <= dis_c;
		FRM_VALID <= 1'b1;
		FRM_DMAC <= da;
		FRM_SMAC <= sa_c;
		FRM_DIP <= ip;
		FRM_IS_IPV4 <= kind[0];
		FRM_IS_IPV6 <= kind[1];
		FRM_IS_CTRL <= kind[2];
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (FRM_READY !== 1'b1 && n < 40);
		FRM_VALID <= 1'b0;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
			if (LEARN_EN === 1'b1) begin
				lrn = 1'b1;
				lmac = LEARN_MAC;
			end
			if (BR_VALID === 1'b1 || L3_VALID === 1'b1) begin
				last = n;
			end
		end while (RES_VALID !== 1'b1 && n < 60);
		chk_flag(RES_VALID, 1'b1);
		chk_flag(FRM_READY, 1'b1);
		chk_flag(n - last == `MFD_RESULT_LATENCY, 1'b1);
		chk_map(RES_PMAP, epm);
		chk_flag(RES_DISCARD, eres[0]);
		chk_flag(RES_FROM_L3, eres[1]);
		chk_flag(RES_CTRL, kind[2] && !l2_c);
		chk_addr({80'h0, RES_MAPPED_MAC}, {80'h0, emac});
		chk_flag(RES_DA_MCAST, da[40]);
		chk_flag(lrn, !sa_c[40]);
		chk_addr({80'h0, lmac}, {80'h0, sa_c[40] ? 48'h0 : sa_c});
		chk_flag(l3_cnt != c3, l3x);
		chk_flag(L3_KEY_IPV6, kind[1]);
		chk_addr({80'h0, br_key_seen}, {80'h0, da});
		if (l3x) begin
			chk_addr(l3_key_seen, ip);
		end
	endtask

	task automatic t_l2_only();
		l2_c = 1'b1;
		dis_c = 1'b1;
		cfg(1'b1, 16'h0301, 1'b1, 16'h000C);
		frame(v4_da, v4_ip, 3'h5, 16'h000C, 2'h0);
		cfg(1'b1, 16'h0301, 1'b0, 16'h000C);
		frame(v6_da, v6_ip, 3'h2, 16'h00F0, 2'h0);
		$display("test l2_only done");
	endtask

	task automatic t_l3_then_bridge();
		l2_c = 1'b0;
		dis_c = 1'b0;
		cfg(1'b1, 16'h0301, 1'b1, 16'h000C);
		l3_dly = 4'h6;
		frame(v4_da, v4_ip, 3'h1, 16'h0301, 2'h2);
		frame(v4_da, 128'hEEABCDEF, 3'h1, 16'h0301, 2'h2);
		cfg(1'b0, 16'h0301, 1'b1, 16'h000C);
		br_dly = 4'h4;
		frame(v6_da, v6_ip, 3'h2, 16'h000C, 2'h0);
		l3_dly = 4'h1;
		br_dly = 4'h1;
		$display("test l3_then_bridge done");
	endtask

	task automatic t_misses();
		l2_c = 1'b0;
		dis_c = 1'b0;
		cfg(1'b0, 16'h0301, 1'b0, 16'h000C);
		frame(v4_da, v4_ip, 3'h1, 16'h00F0, 2'h0);
		dis_c = 1'b1;
		frame(v6_da, v6_ip, 3'h2, 16'h0000, 2'h1);
		frame(48'h0180C200000E, 128'hE0000001, 3'h0, 16'h00F0, 2'h0);
		cfg(1'b1, 16'h0301, 1'b1, 16'h000C);
		frame(v4_da, v4_ip, 3'h5, 16'h0000, 2'h0);
		$display("test misses done");
	endtask

	task automatic t_bounds();
		l2_c = 1'b0;
		dis_c = 1'b0;
		cfg(1'b1, 16'h0301, 1'b1, 16'h0002);
		frame(48'h000011112222, 128'hDFFFFFFF, 3'h1, 16'h0002, 2'h0);
		frame(48'h000011112222, 128'hF0000000, 3'h1, 16'h0002, 2'h0);
		frame(48'h01005E7FFFFF, 128'hEFFFFFFF, 3'h1, 16'h0301, 2'h2);
		frame(48'h333300000001, {8'hFE, 120'h1}, 3'h2, 16'h0002, 2'h0);
		$display("test bounds done");
	endtask

	task automatic t_addresses();
		l2_c = 1'b0;
		dis_c = 1'b1;
		cfg(1'b0, 16'h0301, 1'b1, 16'h8001);
		frame(48'h00AABBCCDDEE, 128'h0A000001, 3'h1, 16'h8001, 2'h0);
		cfg(1'b0, 16'h0301, 1'b0, 16'h8001);
		DEFAULT_MCAST_PORTMAP <= 16'h0A05;
		frame(48'hFFFFFFFFFFFF, 128'h0, 3'h0, 16'h0A05, 2'h0);
		sa_c = 48'h010000000001;
		frame(48'h00AABBCCDDEE, 128'h0, 3'h0, 16'h0A05, 2'h0);
		sa_c = 48'h001122334455;
		$display("test addresses done");
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge CLOCK);
		RST_B <= 1'b1;
		@(posedge CLOCK);
		t_l2_only();
		t_l3_then_bridge();
		t_misses();
		t_bounds();
		t_addresses();
		summarize();
	end

	// Sixteen frames of at most about a dozen cycles each fit well inside this span.
	initial begin
		#200000;
		error_cnt++;
		summarize();
	end
endmodule
`default_nettype wire
